// [sadc_ctrl.sv]
// mode and framing control of a serial 8-bit converter
// assumes: SCLK_I is the host serial clock, CS_N_I the host frame select;
// the converter core delivers its result on RESULT_I before the first data bit
`timescale 1ns/1ps
module sadc_ctrl
    import sadc_pkg::*;
#(
    parameter int RES_W = RESULT_BITS
) (
    input wire logic CLK_SYS_I,
    input wire logic ARST_N_I,
    input wire logic SCLK_I,
    input wire logic CS_N_I,
    input wire logic [RES_W-1:0] RESULT_I,
    output logic SAMPLE_O,
    output logic SER_RESULT_OUT_O,
    output logic SER_RESULT_OE_N_O,
    output logic ANALOG_ON_O,
    output logic TRACKING_O,
    output logic RESULT_VALID_O,
    output logic TRACK_READY_O
);

    // ********************************
    // reset release
    // ********************************
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ********************************
    // link side: frame counting on the serial clock
    // ********************************
    // frame select acts as the frame's own reset, so nothing relies on sclk
    // edges outside a frame
    logic [CNT_W-1:0] falls_q;
    logic [CNT_W-1:0] rises_q;
    logic [RES_W-1:0] shift_q;
    logic dout_q;
    logic frame_rst_n;

    assign frame_rst_n = ARST_N_I & ~CS_N_I;

    // fall counter restarts on every select fall
    always_ff @(negedge SCLK_I or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            falls_q <= CNT_ZERO;
        end else if (falls_q != CNT_MAX) begin
            falls_q <= falls_q + CNT_ONE;
        end
    end

    always_ff @(posedge SCLK_I or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            rises_q <= CNT_ZERO;
        end else if (rises_q != CNT_MAX) begin
            rises_q <= rises_q + CNT_ONE;
        end
    end

    // snapshot at select rise: the counter itself clears while select is high
    logic [CNT_W-1:0] falls_hold_q;

    always_ff @(posedge CS_N_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            falls_hold_q <= CNT_ZERO;
        end else begin
            falls_hold_q <= falls_q;
        end
    end

    // data bit for the slot that the next fall opens; the level before fall one
    // is the first of the leading zeros, so bit seven leaves on fall three
    logic [CNT_W-1:0] slot;
    logic in_data;
    assign slot = falls_q;
    assign in_data = (slot >= CNT_W'(LEAD_ZEROS - 1)) && (slot < CNT_W'(LEAD_ZEROS - 1 + RES_W));

    // result loaded from RESULT_I on the second fall; shifted msb first
    always_ff @(negedge SCLK_I or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            dout_q <= 1'b0;
            shift_q <= '0;
        end else begin
            if (slot == CNT_W'(LEAD_ZEROS - 2)) begin
                shift_q <= RESULT_I;
            end else if (in_data) begin
                shift_q <= {shift_q[RES_W-2:0], 1'b0};
            end
            dout_q <= in_data ? shift_q[RES_W-1] : 1'b0;
        end
    end

    assign SER_RESULT_OUT_O = dout_q;
    // driven while select is low, until the sixteenth fall
    assign SER_RESULT_OE_N_O = CS_N_I | (falls_q >= CNT_W'(FRAME_FALLS));
    assign SAMPLE_O = ~CS_N_I;

    // ********************************
    // crossing to the system clock
    // ********************************
    // select level crosses as a level; the count snapshot is frozen while select is high, so
    // it is stable when sampled after the synchronised rise
    logic cs_n_s;
    logic cs_act_s;
    logic [CNT_W-1:0] falls_s;

    // crossed active high so the synchroniser's reset value is the idle level
    sadc_sync #(.W(1)) u_cs_sync (
        .clk_i(CLK_SYS_I),
        .rst_n_i(rst_n_q),
        .d_i(~CS_N_I),
        .q_o(cs_act_s)
    );
    assign cs_n_s = ~cs_act_s;

    // snapshot is read only once select has been high for a while
    sadc_sync #(.W(CNT_W)) u_cnt_sync (
        .clk_i(CLK_SYS_I),
        .rst_n_i(rst_n_q),
        .d_i(falls_hold_q),
        .q_o(falls_s)
    );

    // ********************************
    // mode decision
    // ********************************
    logic cs_n_q;
    logic cs_n_qq;
    logic cs_fall;
    logic cs_rise_eval;
    power_mode_t mode_q;
    power_mode_t mode_d;
    power_mode_t entry_q;
    logic waking_q;
    logic dummy_q;
    logic [CNT_W-1:0] track_cnt_q;
    frame_info_t info;

    always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cs_n_q <= 1'b1;
            cs_n_qq <= 1'b1;
        end else begin
            cs_n_q <= cs_n_s;
            cs_n_qq <= cs_n_q;
        end
    end

    assign cs_fall = cs_n_q & ~cs_n_s;
    // evaluate one cycle after the synchronised rise so the synchronised count has settled
    assign cs_rise_eval = cs_n_q & ~cs_n_qq & cs_n_s;
    assign info.falls = falls_s;
    assign info.truncated = (falls_s < CNT_W'(FRAME_FALLS));

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            MODE_SHUTDOWN: begin
                if (cs_fall) begin
                    mode_d = MODE_NORMAL;
                end
            end
            MODE_NORMAL: begin
                if (cs_rise_eval) begin
                    if (info.falls < CNT_W'(GLITCH_FALLS)) begin
                        mode_d = entry_q;
                    end else if (info.falls < CNT_W'(KEEP_FALLS)) begin
                        mode_d = MODE_SHUTDOWN;
                    end else begin
                        mode_d = MODE_NORMAL;
                    end
                end
            end
            default: mode_d = MODE_SHUTDOWN;
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q <= MODE_SHUTDOWN;
            entry_q <= MODE_SHUTDOWN;
            waking_q <= 1'b0;
            dummy_q <= 1'b1;
        end else begin
            mode_q <= mode_d;
            if (cs_fall) begin
                entry_q <= mode_q;
                waking_q <= (mode_q == MODE_SHUTDOWN);
            end
            if (cs_rise_eval) begin
                // a full-length wake frame completes power-up
                dummy_q <= waking_q && !(info.falls >= CNT_W'(FRAME_FALLS));
                waking_q <= 1'b0;
            end else if (cs_fall && mode_q == MODE_SHUTDOWN) begin
                dummy_q <= 1'b1;
            end
        end
    end

    // time since the thirteenth rise, for the track interval
    logic tracking;
    assign tracking = CS_N_I ? 1'b1 : (rises_q >= CNT_W'(TRACK_RISE));
    logic track_s;
    sadc_sync #(.W(1)) u_trk_sync (
        .clk_i(CLK_SYS_I),
        .rst_n_i(rst_n_q),
        .d_i(tracking),
        .q_o(track_s)
    );

    always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            track_cnt_q <= CNT_ZERO;
        end else if (!track_s) begin
            track_cnt_q <= CNT_ZERO;
        end else if (track_cnt_q != CNT_W'(TRACK_MIN_CYC)) begin
            track_cnt_q <= track_cnt_q + CNT_ONE;
        end
    end

    analog_ctl_t actl;
    assign actl.analog_on = (mode_q == MODE_NORMAL);
    assign actl.tracking = track_s;
    assign actl.result_valid = ~dummy_q;
    assign ANALOG_ON_O = actl.analog_on;
    assign TRACKING_O = actl.tracking;
    assign RESULT_VALID_O = actl.result_valid;
    assign TRACK_READY_O = (track_cnt_q == CNT_W'(TRACK_MIN_CYC));

    // ********************************
    // checks
    // ********************************
    chk_shutdown_analog_off: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n_q)
        mode_q == MODE_SHUTDOWN |-> !ANALOG_ON_O)
        else $error("analog on in shutdown");
    chk_fall_wakes: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n_q)
        cs_fall |=> mode_q == MODE_NORMAL)
        else $error("select fall did not wake");
    chk_mid_abort_down: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n_q)
        cs_rise_eval && mode_q == MODE_NORMAL && falls_s >= CNT_W'(GLITCH_FALLS)
        && falls_s < CNT_W'(KEEP_FALLS) |=> mode_q == MODE_SHUTDOWN)
        else $error("abort did not shut down");
    chk_glitch_keeps: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n_q)
        cs_rise_eval && falls_s < CNT_W'(GLITCH_FALLS) |=> mode_q == $past(entry_q))
        else $error("glitch changed mode");
    chk_late_stays: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n_q)
        cs_rise_eval && mode_q == MODE_NORMAL && falls_s >= CNT_W'(KEEP_FALLS)
        |=> mode_q == MODE_NORMAL)
        else $error("late rise left normal mode");
    chk_shutdown_holds: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n_q)
        mode_q == MODE_SHUTDOWN && !cs_fall |=> mode_q == MODE_SHUTDOWN)
        else $error("left shutdown without select fall");
    chk_wake_invalid: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n_q)
        cs_fall && mode_q == MODE_SHUTDOWN |=> !RESULT_VALID_O [*2])
        else $error("wake result marked valid");
    chk_oe_idle: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n_q)
        cs_n_s && cs_n_q && CS_N_I |-> SER_RESULT_OE_N_O)
        else $error("output driven while deselected");

endmodule // sadc_ctrl

// [sadc_host.sv]
// host serial port model: drives frame select and serial clock, captures the result
// assumes: result bit changes on serial clock falls; clock stands high between frames
`timescale 1ns/1ps
module sadc_host (
    output logic sclk_o,
    output logic cs_n_o,
    input wire logic sdo_i,
    input wire logic oe_n_i
);
    localparam real HALF_NS = 62.5;
    logic last_q = 1'b0;
    logic oe_end = 1'b0;
    // released line shows the inverse of the last bit, never a stale copy
    wire line = oe_n_i ? ~last_q : sdo_i;
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
    end
    always @(negedge sclk_o) if (!oe_n_i) last_q <= sdo_i;
    // ****************************************
    // one frame of n falls; slot k read just before fall k+1
    // ****************************************
    task automatic run_frame(input int n, output logic [15:0] word);
        word = 16'h0000;
        cs_n_o = 1'b0;
        #(HALF_NS);
        for (int k = 0; k < n; k++) begin
            word[15-k] = line;
            sclk_o = 1'b0;
            #(HALF_NS);
            sclk_o = 1'b1;
            #(HALF_NS);
        end
        oe_end = oe_n_i;
        cs_n_o = 1'b1;
    endtask
endmodule // sadc_host

// [sadc_pkg.sv]
// package for the serial converter mode and framing control
// assumes: one system clock domain plus a serial link clock domain
package sadc_pkg;

    localparam int RESULT_BITS = 8;
    localparam int LEAD_ZEROS = 3;
    localparam int FRAME_FALLS = 16;
    localparam int GLITCH_FALLS = 2;
    localparam int KEEP_FALLS = 10;
    localparam int TRACK_RISE = 13;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
    localparam int SYS_PERIOD_NS = 50;
    localparam int TRACK_MIN_NS = 350;
    localparam int TRACK_MIN_CYC = (TRACK_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

    typedef enum logic {
        MODE_SHUTDOWN,
        MODE_NORMAL
    } power_mode_t;

    // summary of one finished frame, handed from link side to system side
    typedef struct packed {
        logic [CNT_W-1:0] falls;
        logic truncated;
    } frame_info_t;

    // analog control lines
    typedef struct packed {
        logic analog_on;
        logic tracking;
        logic result_valid;
    } analog_ctl_t;

endpackage

// [sadc_sync.sv]
// two-flop level synchroniser
// assumes: input is asynchronous to clk_i
`timescale 1ns/1ps
module sadc_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule // sadc_sync

// [tb.sv]
// self-checking bench for the converter mode and framing control
// assumes: host model owns the link pins; frames start off the system clock edges
`timescale 1ns/1ps
module tb;
    import sadc_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [RESULT_BITS-1:0] result = 8'h00;
    logic [15:0] w;
    wire sclk, cs_n, sample, sdo, oe_n, analog_on, tracking, res_valid, track_ready;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    always #25 clk_sys = ~clk_sys;
    sadc_ctrl uut (
        .CLK_SYS_I(clk_sys),
        .ARST_N_I(arst_n),
        .SCLK_I(sclk),
        .CS_N_I(cs_n),
        .RESULT_I(result),
        .SAMPLE_O(sample),
        .SER_RESULT_OUT_O(sdo),
        .SER_RESULT_OE_N_O(oe_n),
        .ANALOG_ON_O(analog_on),
        .TRACKING_O(tracking),
        .RESULT_VALID_O(res_valid),
        .TRACK_READY_O(track_ready)
    );
    sadc_host host (.sclk_o(sclk), .cs_n_o(cs_n), .sdo_i(sdo), .oe_n_i(oe_n));
    // ****************************************
    // shared helpers
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        if (bad_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            test_done();
        end
    end
    // frame offset by 13ns keeps link edges clear of system edges
    task automatic frame(input int n);
        @(posedge clk_sys);
        #13;
        fork
            host.run_frame(n, w);
            begin
                #20;
                chk({14'h0, oe_n, sample}, 16'h1);
                if (n >= 5) begin
                    #580;
                    chk({14'h0, analog_on, tracking}, 16'h2);
                end
            end
        join
        #1;
        chk({15'h0, oe_n}, 16'h1);
        // idle covers the quiet interval and 350ns after the 13th rise
        repeat (12) @(posedge clk_sys);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_wake;
        chk({15'h0, res_valid}, 16'h0);
        frame(16);
        chk({14'h0, analog_on, res_valid}, 16'h3);
    endtask
    task automatic t_data;
        logic [7:0] v [2] = '{8'ha5, 8'h3c};
        foreach (v[i]) begin
            result <= v[i];
            frame(16);
            chk(w, {3'h0, v[i], 5'h00});
            chk({15'h0, host.oe_end}, 16'h1);
            chk({13'h0, analog_on, tracking, track_ready}, 16'h7);
        end
    endtask
    task automatic t_trunc;
        result <= 8'hff;
        frame(12);
        chk(w[15:4], {3'h0, 8'hff, 1'b0});
        chk({14'h0, host.oe_end, analog_on}, 16'h1);
        frame(1);
        chk({15'h0, analog_on}, 16'h1);
    endtask
    task automatic t_shut;
        frame(5);
        chk({15'h0, analog_on}, 16'h0);
        repeat (40) @(posedge clk_sys);
        chk({15'h0, analog_on}, 16'h0);
        frame(1);
        chk({15'h0, analog_on}, 16'h0);
        frame(8);
        chk({15'h0, analog_on}, 16'h0);
        frame(16);
        chk({14'h0, analog_on, res_valid}, 16'h3);
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_wake();
        t_data();
        t_trunc();
        t_shut();
        test_done();
    end
endmodule // tb
